// File: verilog/sst_pkg.sv
// constants and carrier types of the stop and torque limit block
package sst_pkg;
    localparam int TW = 11;
    localparam int SW = 16;
    localparam int IRQ_W = 4;

    localparam logic [4:0] ADDR_CTRL     = 5'h00;
    localparam logic [4:0] ADDR_EMG_TRQ  = 5'h04;
    localparam logic [4:0] ADDR_FWD_LIM  = 5'h08;
    localparam logic [4:0] ADDR_REV_LIM  = 5'h0C;
    localparam logic [4:0] ADDR_MONITOR  = 5'h10;
    localparam logic [4:0] ADDR_IRQ_STAT = 5'h14;
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h18;

    localparam int CTRL_FSEL  = 4;
    localparam int CTRL_COAST = 6;
    localparam int CTRL_HOLD  = 7;
    localparam int CTRL_OTDEC = 8;
    localparam int CTRL_OTZC  = 9;
    localparam logic [15:0] CTRL_RESET = 16'h0080;

    localparam int MON_LIMIT = 4;
    localparam int MON_STATE = 8;
    localparam int MON_POWER = 12;
    localparam int MON_BRAKE = 13;
    localparam int MON_ZCLMP = 14;

    localparam int IRQ_SOFF  = 0;
    localparam int IRQ_OT    = 1;
    localparam int IRQ_LIMIT = 2;
    localparam int IRQ_STILL = 3;

    typedef enum logic [2:0] {
        ST_RUN    = 3'b000,
        ST_DBRAKE = 3'b001,
        ST_COAST  = 3'b010,
        ST_DECEL  = 3'b011,
        ST_ZCLAMP = 3'b100,
        ST_OFF    = 3'b101,
        ST_HOLD   = 3'b110
    } sst_stop_t;

    typedef struct packed {
        logic servoOn;
        logic forwardTravelBlock;
        logic reverseTravelBlock;
        logic mainPowerOk;
    } sst_pins_t;

    typedef struct packed {
        logic motorPowerOn;
        logic dynBrakeOn;
        logic zeroClamp;
        logic decelActive;
    } sst_drive_t;

    typedef struct packed {
        sst_pins_t               syncA;
        sst_pins_t               syncB;
        logic [15:0]             ctrl;
        logic [TW-2:0]           emergency_stop_torque;
        logic [TW-2:0]           fwdLim;
        logic [TW-2:0]           revLim;
        logic [IRQ_W-1:0]        irqStat;
        logic [IRQ_W-1:0]        irqMask;
        sst_stop_t               stop;
        logic                    latHold;
        logic                    latZc;
        sst_drive_t              drive;
        logic signed [TW-1:0]    torqueCmd;
        logic                    limitHit;
        logic                    limitOut;
        logic                    limitOutN;
        logic                    irq;
        logic                    waitReq;
        logic [31:0]             rdata;
    } sst_state_t;
endpackage

// File: verilog/sst_stop_torque.sv
// stop sequencing and torque limiting for a servo drive
//
// Chosen here: the Avalon-MM register port and the register addresses.
module sst_stop_torque #(
    parameter int MAX_TORQUE  = 300,
    parameter int STILL_SPEED = 1
) (
    input  wire logic                       ref_clk,
    input  wire logic                       srst,
    input  wire logic [4:0]                 avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    input  wire logic [3:0]                 avs_byteenable,
    output logic [31:0]                     avs_readdata,
    output logic                            avs_waitrequest,
    input  wire sst_pkg::sst_pins_t         pinIn,
    input  wire logic                       servoAlarm,
    input  wire logic                       torqueMode,
    input  wire logic signed [sst_pkg::TW-1:0] torqueRef,
    input  wire logic signed [sst_pkg::SW-1:0] motorSpeed,
    output sst_pkg::sst_drive_t             drive,
    output logic signed [sst_pkg::TW-1:0]   torqueCmd,
    output logic                            torqueLimitOutPos,
    output logic                            torqueLimitOutNegN,
    output logic                            irq
);
    localparam int TW = sst_pkg::TW;
    localparam int IRQ_W_L = sst_pkg::IRQ_W;
    localparam logic [TW-2:0] MAXV = (TW-1)'(MAX_TORQUE);
    localparam logic [sst_pkg::SW-1:0] STILLV =
        sst_pkg::SW'(STILL_SPEED);

    if (MAX_TORQUE < 1 || MAX_TORQUE > (1 << (TW - 1)) - 1) begin : g_chk
        $error("MAX_TORQUE out of range");
    end
    if (STILL_SPEED < 0
        || STILL_SPEED > (1 << (sst_pkg::SW - 1)) - 1) begin : g_chk2
        $error("STILL_SPEED out of range");
    end

    sst_pkg::sst_state_t s;
    sst_pkg::sst_state_t next_s;
    logic                soffCond;
    logic                otCond;
    logic                still;
    logic                fwdOver;
    logic                revOver;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // written percentages saturate at maximum torque
    function automatic logic [TW-2:0] satPct(input logic [15:0] v);
        satPct = (v > 16'(MAXV)) ? MAXV : v[TW-2:0];
    endfunction

    function automatic logic signed [TW-1:0] toS(input logic [TW-2:0] v);
        toS = $signed({1'b0, v});
    endfunction

    // servo-off stop method from the coast bit
    function automatic sst_pkg::sst_stop_t offStop(input logic coast);
        offStop = coast ? sst_pkg::ST_COAST : sst_pkg::ST_DBRAKE;
    endfunction

    function automatic sst_pkg::sst_drive_t driveOf(
        input sst_pkg::sst_stop_t st);
        driveOf = '0;
        case (st)
            sst_pkg::ST_RUN:    driveOf.motorPowerOn = 1'b1;
            sst_pkg::ST_DBRAKE: driveOf.dynBrakeOn = 1'b1;
            sst_pkg::ST_HOLD:   driveOf.dynBrakeOn = 1'b1;
            sst_pkg::ST_DECEL: begin
                driveOf.motorPowerOn = 1'b1;
                driveOf.decelActive = 1'b1;
            end
            sst_pkg::ST_ZCLAMP: begin
                driveOf.motorPowerOn = 1'b1;
                driveOf.zeroClamp = 1'b1;
            end
            default:            driveOf = '0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // conditions from synchronised pins, servoAlarm, motor speed and torque reference

    assign soffCond = !s.syncB.servoOn || servoAlarm
                      || !s.syncB.mainPowerOk;
    assign otCond = s.syncB.forwardTravelBlock
                    || s.syncB.reverseTravelBlock;
    assign still = (motorSpeed < 0) ? ((-motorSpeed) <= $signed(STILLV))
                                    : (motorSpeed <= $signed(STILLV));
    assign fwdOver = torqueRef > toS(s.fwdLim);
    assign revOver = torqueRef < -toS(s.revLim);

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [IRQ_W_L-1:0] ev;
        logic [IRQ_W_L-1:0] clr;
        ev = '0;
        clr = '0;
        next_s = s;
        next_s.syncA = pinIn;
        next_s.syncB = s.syncA;

        case (s.stop)
            sst_pkg::ST_RUN: begin
                if (soffCond) begin
                    next_s.stop = offStop(s.ctrl[sst_pkg::CTRL_COAST]);
                    next_s.latHold = s.ctrl[sst_pkg::CTRL_HOLD];
                    ev[sst_pkg::IRQ_SOFF] = 1'b1;
                end else if (otCond) begin
                    ev[sst_pkg::IRQ_OT] = 1'b1;
                    next_s.latHold = s.ctrl[sst_pkg::CTRL_HOLD];
                    next_s.latZc = s.ctrl[sst_pkg::CTRL_OTZC];
                    if (torqueMode || !s.ctrl[sst_pkg::CTRL_OTDEC]) begin
                        next_s.stop = offStop(s.ctrl[sst_pkg::CTRL_COAST]);
                    end else begin
                        next_s.stop = sst_pkg::ST_DECEL;
                    end
                end
            end
            sst_pkg::ST_DECEL: begin
                if (soffCond) begin
                    next_s.stop = offStop(s.ctrl[sst_pkg::CTRL_COAST]);
                    next_s.latHold = s.ctrl[sst_pkg::CTRL_HOLD];
                    ev[sst_pkg::IRQ_SOFF] = 1'b1;
                end else if (still) begin
                    next_s.stop = s.latZc ? sst_pkg::ST_ZCLAMP
                                          : sst_pkg::ST_OFF;
                    ev[sst_pkg::IRQ_STILL] = 1'b1;
                end
            end
            sst_pkg::ST_DBRAKE: begin
                if (still) begin
                    next_s.stop = s.latHold ? sst_pkg::ST_HOLD
                                            : sst_pkg::ST_OFF;
                    ev[sst_pkg::IRQ_STILL] = 1'b1;
                end
            end
            sst_pkg::ST_COAST: begin
                if (still) begin
                    next_s.stop = sst_pkg::ST_OFF;
                    ev[sst_pkg::IRQ_STILL] = 1'b1;
                end
            end
            sst_pkg::ST_ZCLAMP: begin
                if (soffCond) begin
                    next_s.stop = offStop(s.ctrl[sst_pkg::CTRL_COAST]);
                    next_s.latHold = s.ctrl[sst_pkg::CTRL_HOLD];
                    ev[sst_pkg::IRQ_SOFF] = 1'b1;
                end else if (!otCond) begin
                    next_s.stop = sst_pkg::ST_RUN;
                end
            end
            sst_pkg::ST_OFF, sst_pkg::ST_HOLD: begin
                if (!soffCond && !otCond) begin
                    next_s.stop = sst_pkg::ST_RUN;
                end
            end
            default: next_s.stop = sst_pkg::ST_OFF;
        endcase

        next_s.drive = driveOf(next_s.stop);
        case (next_s.stop)
            sst_pkg::ST_RUN: begin
                if (fwdOver) begin
                    next_s.torqueCmd = toS(s.fwdLim);
                end else if (revOver) begin
                    next_s.torqueCmd = -toS(s.revLim);
                end else begin
                    next_s.torqueCmd = torqueRef;
                end
            end
            sst_pkg::ST_DECEL: begin
                // braking torque opposes the direction of motion
                next_s.torqueCmd = (motorSpeed > 0) ? -toS(s.emergency_stop_torque)
                                                    : toS(s.emergency_stop_torque);
            end
            default: next_s.torqueCmd = '0;
        endcase

        next_s.limitHit = fwdOver || revOver;
        next_s.limitOut = next_s.limitHit
                          && !s.ctrl[sst_pkg::CTRL_FSEL];
        next_s.limitOutN = !next_s.limitOut;
        ev[sst_pkg::IRQ_LIMIT] = next_s.limitHit && !s.limitHit;

        // bus slave: one wait cycle, then the answer
        if ((avs_read || avs_write) && s.waitReq) begin
            next_s.waitReq = 1'b0;
            case (avs_address)
                sst_pkg::ADDR_CTRL:     next_s.rdata = {16'h0000, s.ctrl};
                sst_pkg::ADDR_EMG_TRQ:  next_s.rdata = 32'(s.emergency_stop_torque);
                sst_pkg::ADDR_FWD_LIM:  next_s.rdata = 32'(s.fwdLim);
                sst_pkg::ADDR_REV_LIM:  next_s.rdata = 32'(s.revLim);
                sst_pkg::ADDR_MONITOR: begin
                    next_s.rdata = '0;
                    next_s.rdata[sst_pkg::MON_LIMIT] = s.limitOut;
                    next_s.rdata[sst_pkg::MON_STATE +: 3] = s.stop;
                    next_s.rdata[sst_pkg::MON_POWER] = s.drive.motorPowerOn;
                    next_s.rdata[sst_pkg::MON_BRAKE] = s.drive.dynBrakeOn;
                    next_s.rdata[sst_pkg::MON_ZCLMP] = s.drive.zeroClamp;
                end
                sst_pkg::ADDR_IRQ_STAT: next_s.rdata = 32'(s.irqStat);
                sst_pkg::ADDR_IRQ_MASK: next_s.rdata = 32'(s.irqMask);
                default:                next_s.rdata = '0;
            endcase
        end else begin
            next_s.waitReq = 1'b1;
            if (avs_write && !s.waitReq) begin
                case (avs_address)
                    sst_pkg::ADDR_CTRL: next_s.ctrl =
                        merge16(s.ctrl, avs_writedata, avs_byteenable);
                    sst_pkg::ADDR_EMG_TRQ: next_s.emergency_stop_torque = satPct(merge16(
                        16'(s.emergency_stop_torque), avs_writedata, avs_byteenable));
                    sst_pkg::ADDR_FWD_LIM: next_s.fwdLim = satPct(merge16(
                        16'(s.fwdLim), avs_writedata, avs_byteenable));
                    sst_pkg::ADDR_REV_LIM: next_s.revLim = satPct(merge16(
                        16'(s.revLim), avs_writedata, avs_byteenable));
                    sst_pkg::ADDR_IRQ_STAT:
                        if (avs_byteenable[0]) clr = avs_writedata[IRQ_W_L-1:0];
                    sst_pkg::ADDR_IRQ_MASK:
                        if (avs_byteenable[0]) begin
                            next_s.irqMask = avs_writedata[IRQ_W_L-1:0];
                        end
                    default: next_s.ctrl = s.ctrl;
                endcase
            end
        end

        // set wins over a write-one clear in the same cycle
        next_s.irqStat = (s.irqStat & ~clr) | ev;
        next_s.irq = |(next_s.irqStat & next_s.irqMask);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s <= '0;
            s.ctrl <= sst_pkg::CTRL_RESET;
            s.emergency_stop_torque <= MAXV;
            s.fwdLim <= MAXV;
            s.revLim <= MAXV;
            s.stop <= sst_pkg::ST_OFF;
            s.limitOutN <= 1'b1;
            s.waitReq <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign avs_readdata = s.rdata;
    assign avs_waitrequest = s.waitReq;
    assign drive = s.drive;
    assign torqueCmd = s.torqueCmd;
    assign torqueLimitOutPos = s.limitOut;
    assign torqueLimitOutNegN = s.limitOutN;
    assign irq = s.irq;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    ot_same_stop_a: assert property (
        s.stop == sst_pkg::ST_RUN && !soffCond && otCond
        && !s.ctrl[sst_pkg::CTRL_OTDEC]
        |=> s.stop == offStop($past(s.ctrl[sst_pkg::CTRL_COAST])))
        else $error("overtravel stop differs from servo-off stop");

    ot_decel_a: assert property (
        s.stop == sst_pkg::ST_RUN && !soffCond && otCond && !torqueMode
        && s.ctrl[sst_pkg::CTRL_OTDEC]
        |=> s.stop == sst_pkg::ST_DECEL && s.drive.decelActive)
        else $error("overtravel did not start deceleration");

    decel_after_a: assert property (
        s.stop == sst_pkg::ST_DECEL && !soffCond && still
        |=> s.stop == ($past(s.latZc) ? sst_pkg::ST_ZCLAMP : sst_pkg::ST_OFF))
        else $error("wrong state after deceleration stop");

    torque_mode_a: assert property (
        s.stop == sst_pkg::ST_RUN && otCond && torqueMode
        |=> s.stop != sst_pkg::ST_DECEL)
        else $error("deceleration used in torque mode");

    emg_torque_a: assert property (
        s.stop == sst_pkg::ST_DECEL
        |-> s.torqueCmd == toS($past(s.emergency_stop_torque))
            || s.torqueCmd == -toS($past(s.emergency_stop_torque)))
        else $error("braking torque not the emergency value");

    servo_off_a: assert property (
        s.stop == sst_pkg::ST_RUN && soffCond
        |=> (s.stop == sst_pkg::ST_DBRAKE || s.stop == sst_pkg::ST_COAST)
            && !s.drive.motorPowerOn)
        else $error("servo off not entered");

    coast_power_a: assert property (
        s.stop == sst_pkg::ST_COAST
        |-> !s.drive.motorPowerOn && !s.drive.dynBrakeOn)
        else $error("coasting with power or brake");

    brake_hold_a: assert property (
        s.stop == sst_pkg::ST_DBRAKE && still
        |=> s.stop == ($past(s.latHold) ? sst_pkg::ST_HOLD : sst_pkg::ST_OFF)
            && s.drive.dynBrakeOn == $past(s.latHold))
        else $error("brake not held or released as latched");

    torque_clamp_a: assert property (
        s.stop == sst_pkg::ST_RUN
        |-> s.torqueCmd <= toS($past(s.fwdLim))
            && s.torqueCmd >= -toS($past(s.revLim)))
        else $error("torque command beyond limit");

    limit_range_a: assert property (
        s.fwdLim <= MAXV && s.revLim <= MAXV && s.emergency_stop_torque <= MAXV)
        else $error("percentage above maximum torque");

    limit_out_a: assert property (
        (fwdOver || revOver) && !s.ctrl[sst_pkg::CTRL_FSEL]
        |=> s.limitOut && !s.limitOutN ##1 s.irqStat[sst_pkg::IRQ_LIMIT])
        else $error("torque limit not indicated");

    limit_open_a: assert property (
        !fwdOver && !revOver |=> !s.limitOut && s.limitOutN)
        else $error("contact closed at or below limit");

    latch_hold_a: assert property (
        s.stop == sst_pkg::ST_DBRAKE || s.stop == sst_pkg::ST_DECEL
        |=> $stable(s.latZc) && ($past(s.stop) == sst_pkg::ST_DECEL
            || $stable(s.latHold)))
        else $error("latched stop selection changed mid stop");

    decel_clamp_c: cover property (
        s.stop == sst_pkg::ST_DECEL ##1 s.stop == sst_pkg::ST_ZCLAMP);
    brake_hold_c: cover property (
        s.stop == sst_pkg::ST_DBRAKE ##1 s.stop == sst_pkg::ST_HOLD);
    coast_off_c: cover property (
        s.stop == sst_pkg::ST_COAST ##1 s.stop == sst_pkg::ST_OFF);
    limit_irq_c: cover property (s.limitOut && s.irq);
endmodule

// File: testbench/sst_motor_model.sv
// motor and power stage model that turns torque into speed
module sst_motor_model (
    input  wire logic                          ref_clk,
    input  wire logic                          srst,
    input  wire sst_pkg::sst_drive_t           drive,
    input  wire logic signed [sst_pkg::TW-1:0] torqueCmd,
    output logic signed [sst_pkg::SW-1:0]      motorSpeed
);
    timeunit 1ns;
    timeprecision 100ps;
    logic signed [sst_pkg::SW-1:0] nextSpeed;
    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nextSpeed = motorSpeed;
        if (drive.motorPowerOn) begin
            nextSpeed = motorSpeed + 16'(torqueCmd >>> 2);
        end else if (drive.dynBrakeOn) begin
            nextSpeed = motorSpeed >>> 1;
        end else if (motorSpeed != 16'sh0000) begin
            // friction only: slow coast
            nextSpeed = motorSpeed - (motorSpeed > 0 ? 16'sh0001 : -16'sh0001);
        end
        // braking never reverses the shaft
        if ((motorSpeed > 0 && nextSpeed < 0) ||
            (motorSpeed < 0 && nextSpeed > 0)) begin
            nextSpeed = 16'sh0000;
        end
        if (nextSpeed > 16'sh1F40) begin
            nextSpeed = 16'sh1F40;
        end
        if (nextSpeed < -16'sh1F40) begin
            nextSpeed = -16'sh1F40;
        end
    end
    always_ff @(posedge ref_clk) begin
        motorSpeed <= srst ? 16'sh0000 : nextSpeed;
    end
endmodule

// File: testbench/tb_top.sv
// self-checking bench of the stop and torque limit block
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int MAXT = 300;
    logic                          ref_clk;
    logic                          srst;
    logic [4:0]                    avs_address;
    logic                          avs_read;
    logic                          avs_write;
    logic [31:0]                   avs_writedata;
    logic [31:0]                   avs_readdata;
    logic                          avs_waitrequest;
    sst_pkg::sst_pins_t            pinIn;
    logic                          servoAlarm;
    logic                          torqueMode;
    logic signed [sst_pkg::TW-1:0] torqueRef;
    logic signed [sst_pkg::SW-1:0] motorSpeed;
    sst_pkg::sst_drive_t           drive;
    logic signed [sst_pkg::TW-1:0] torqueCmd;
    logic                          torqueLimitOutPos;
    logic                          torqueLimitOutNegN;
    logic                          irq;
    int                            fails = 0;
    int                            compares = 0;
    sst_pkg::sst_stop_t offEnd [4] = '{sst_pkg::ST_OFF, sst_pkg::ST_OFF,
        sst_pkg::ST_HOLD, sst_pkg::ST_OFF};
    sst_pkg::sst_stop_t otEnd [4] = '{sst_pkg::ST_OFF, sst_pkg::ST_ZCLAMP,
        sst_pkg::ST_HOLD, sst_pkg::ST_HOLD};
    logic [4:0] ra [4] = '{5'h00, 5'h08, 5'h0C, 5'h1C};
    int         rx [4] = '{32'h0080, MAXT, MAXT, 0};
    ////////////////////////////////////////////////////////////////////////
    sst_stop_torque #(.MAX_TORQUE(MAXT), .STILL_SPEED(1)) uut (
        .ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pinIn(pinIn), .servoAlarm(servoAlarm), .torqueMode(torqueMode),
        .torqueRef(torqueRef), .motorSpeed(motorSpeed), .drive(drive),
        .torqueCmd(torqueCmd), .torqueLimitOutPos(torqueLimitOutPos),
        .torqueLimitOutNegN(torqueLimitOutNegN), .irq(irq));
    sst_motor_model motor (.ref_clk(ref_clk), .srst(srst), .drive(drive),
        .torqueCmd(torqueCmd), .motorSpeed(motorSpeed));
    ////////////////////////////////////////////////////////////////////////
    function automatic int clampT(int r, int f, int v);
        return r > f ? f : (r < -v ? -v : r);
    endfunction
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic xfer(logic w, logic [4:0] a, logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        if (n >= 40) fails++;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(logic [4:0] a, logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(logic [4:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0000_0000, q);
    endtask
    task automatic waitState(sst_pkg::sst_stop_t st, string what);
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            rd(sst_pkg::ADDR_MONITOR, q);
            n++;
        end while (q[10:8] !== st && n < 900);
        check(what, 32'(q[10:8]), 32'(st));
    endtask
    task automatic goRun();
        pinIn <= 4'b1001;
        servoAlarm <= 1'b0;
        torqueMode <= 1'b0;
        waitState(sst_pkg::ST_RUN, "run");
    endtask
    task automatic spin();
        int n;
        n = 0;
        torqueRef <= 11'sh0C8;
        while (motorSpeed < 2000 && n < 900) begin
            @(posedge ref_clk);
            n++;
        end
        torqueRef <= 11'sh000;
        @(posedge ref_clk);
    endtask
    task automatic report_and_stop();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        fails++;
        report_and_stop();
    end
    initial begin
        logic [31:0] q;
        int          e;
        int          f;
        int          v;
        int          r;
        logic        lim;
        srst = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        pinIn = 4'b0000;
        servoAlarm = 1'b0;
        torqueMode = 1'b0;
        torqueRef = 11'sh000;
        void'($urandom(32'h1284_0643));
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            rd(ra[i], q);
            check("reset", q, 32'(rx[i]));
        end
        wr(sst_pkg::ADDR_EMG_TRQ, 32'h0000_03E7);
        rd(sst_pkg::ADDR_EMG_TRQ, q);
        check("emgsat", q, 32'(MAXT));
        $display("test reset done");
        goRun();
        for (int i = 0; i < 24; i++) begin
            f = $urandom_range(MAXT);
            v = $urandom_range(MAXT);
            r = int'($urandom_range(800)) - 400;
            if (i % 4 == 1) r = f;
            if (i % 4 == 2) r = -v - 1;
            wr(sst_pkg::ADDR_FWD_LIM, 32'(f));
            wr(sst_pkg::ADDR_REV_LIM, 32'(v));
            torqueRef <= 11'(r);
            repeat (3) @(posedge ref_clk);
            lim = (r > f) || (r < -v);
            check("cmd", 32'(torqueCmd), 32'(clampT(r, f, v)));
            check("out", 32'(torqueLimitOutPos), 32'(lim));
            check("outn", 32'(torqueLimitOutNegN), 32'(!lim));
            rd(sst_pkg::ADDR_MONITOR, q);
            check("mon", 32'(q[4]), 32'(lim));
        end
        wr(sst_pkg::ADDR_CTRL, 32'h0000_0090);
        wr(sst_pkg::ADDR_FWD_LIM, 32'h0000_0064);
        torqueRef <= 11'sh096;
        repeat (3) @(posedge ref_clk);
        check("fsel", 32'(torqueLimitOutPos), 32'h0000_0000);
        wr(sst_pkg::ADDR_CTRL, 32'h0000_0080);
        wr(sst_pkg::ADDR_FWD_LIM, 32'(MAXT));
        wr(sst_pkg::ADDR_REV_LIM, 32'(MAXT));
        $display("test torque limit done");
        for (int k = 0; k < 4; k++) begin
            wr(sst_pkg::ADDR_CTRL, 32'({k[1], k[0], 6'h00}));
            spin();
            case (k % 3)
                0: pinIn.servoOn <= 1'b0;
                1: servoAlarm <= 1'b1;
                default: pinIn.mainPowerOk <= 1'b0;
            endcase
            repeat (4) @(posedge ref_clk);
            check("power", 32'(drive.motorPowerOn), 32'h0000_0000);
            check("brake", 32'(drive.dynBrakeOn), 32'(!k[0]));
            // hold bit flipped after the event must not matter
            wr(sst_pkg::ADDR_CTRL, 32'({~k[1], k[0], 6'h00}));
            waitState(offEnd[k], "soff");
            check("held", 32'(drive.dynBrakeOn), 32'(k == 2));
            goRun();
        end
        $display("test servo off done");
        for (int j = 0; j < 4; j++) begin
            e = 20 + $urandom_range(60);
            wr(sst_pkg::ADDR_EMG_TRQ, 32'(e));
            wr(sst_pkg::ADDR_CTRL, 32'({j[0], j < 3, 1'b1, 7'h00}));
            torqueMode <= (j == 2);
            spin();
            if (j[0]) pinIn.reverseTravelBlock <= 1'b1;
            else pinIn.forwardTravelBlock <= 1'b1;
            repeat (5) @(posedge ref_clk);
            check("decel", 32'(drive.decelActive), 32'(j < 2));
            if (j < 2) check("emg", 32'(torqueCmd), 32'(-e));
            wr(sst_pkg::ADDR_CTRL, 32'({~j[0], j < 3, 1'b1, 7'h00}));
            waitState(otEnd[j], "ot");
            check("zc", 32'(drive.zeroClamp), 32'(j == 1));
            goRun();
        end
        $display("test overtravel done");
        rd(sst_pkg::ADDR_IRQ_STAT, q);
        check("stat", q, 32'h0000_000F);
        check("irq0", 32'(irq), 32'h0000_0000);
        wr(sst_pkg::ADDR_IRQ_MASK, 32'h0000_0004);
        repeat (2) @(posedge ref_clk);
        check("irq1", 32'(irq), 32'h0000_0001);
        wr(sst_pkg::ADDR_IRQ_STAT, 32'h0000_0004);
        repeat (2) @(posedge ref_clk);
        check("irq2", 32'(irq), 32'h0000_0000);
        rd(sst_pkg::ADDR_IRQ_STAT, q);
        check("clr", q, 32'h0000_000B);
        $display("test interrupt done");
        report_and_stop();
    end
endmodule
